/* File: hw/exec_pkg.sv */
// shared types and constants for the move, return and rotate execution group
package exec_pkg;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 6;
  localparam int PC_W        = 10;
  localparam int FILE_WORDS  = 64;
  localparam int STACK_DEPTH = 8;

  localparam logic                DEST_ACC   = 1'h0;
  localparam logic                DEST_FILE  = 1'h1;
  localparam logic [DATA_W-1:0]   ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0]   ZERO_VALUE = 8'h00;
  localparam logic [PC_W-1:0]     PC_RESET   = 10'h000;
  localparam logic [PC_W-1:0]     PC_STEP    = 10'h001;
  localparam logic                FLAG_RESET = 1'h0;
  localparam logic                GIE_RESET  = 1'h0;
  localparam logic                GIE_ON     = 1'h1;
  localparam int                  MSB        = DATA_W - 1;

  // execution length of each instruction in core cycles
  localparam int CYCLES_SHORT = 1;
  localparam int CYCLES_LONG  = 2;

  typedef enum logic [3:0] {
    op_idle_instruction,
    op_load_literal_to_accumulator,
    op_store_accumulator_to_file,
    op_copy_file_register,
    op_exit_with_literal,
    op_interrupt_exit_enable,
    op_subroutine_exit,
    op_rotate_left_via_carry,
    op_rotate_right_via_carry,
    op_far_subroutine_jump
  } opcode_t;

  typedef struct packed {
    opcode_t             opcode;
    logic [DATA_W-1:0]   literal;
    logic [ADDR_W-1:0]   file_addr;
    logic                dest_sel;
    logic [PC_W-1:0]     target;
  } instr_t;

  typedef struct packed {
    logic                en;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } file_wr_t;

endpackage : exec_pkg

/* File: hw/move_return_rotate_exec.sv */
// execution of moves, idle, returns, rotates and the far call of the core
`timescale 1ns/10ps

// Functional notes
// - load literal puts the 8-bit operand in the accumulator, one cycle, flags kept.
// - store copies accumulator into file register 0..63, one cycle, flags kept.
// - copy reads a file register into accumulator or back into itself, one cycle.
// - copy sets zero flag when the moved value is zero, clears it otherwise.
// - exit with literal loads accumulator, pops return address, sets irq allow, 2 cycles.
// - every return pops the stack, level drops by one after reading the top.
// - interrupt exit pops return address, sets irq allow, 2 cycles, no flag changes.
// - subroutine exit pops return address in 2 cycles, nothing else changes.
// - rotate left: old carry to bit 0, bits 6..0 up, bit 7 to carry.
// - rotate right: old carry to bit 7, bits 7..1 down, bit 0 to carry.
// - rotates write accumulator when destination bit is 0, the source register when 1.
// - far call pushes the next instruction address so a return resumes after it.
module move_return_rotate_exec
  import exec_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  // decoded instruction from the decoder
  input  wire logic                         instr_valid,
  input  wire exec_pkg::instr_t             instr,
  // progress
  output logic                              busy_r,
  output logic                              done_r,
  // architectural state
  output logic      [exec_pkg::DATA_W-1:0]  acc_r,
  output logic                              zero_r,
  output logic                              carry_r,
  output logic                              gie_r,
  output logic      [exec_pkg::PC_W-1:0]    pc_r,
  output logic      [$clog2(DEPTH)-1:0]     stack_level_r,
  // file register write notice
  output exec_pkg::file_wr_t                file_wr_r
);

  import exec_pkg::*;

  typedef enum logic {st_ready, st_second} state_t;

  function automatic logic is_return(input opcode_t op);
    is_return = (op == op_exit_with_literal) || (op == op_interrupt_exit_enable) ||
                (op == op_subroutine_exit);
  endfunction : is_return

  function automatic logic is_rotate(input opcode_t op);
    is_rotate = (op == op_rotate_left_via_carry) || (op == op_rotate_right_via_carry);
  endfunction : is_rotate

  state_t                 state_r;
  state_t                 state_nxt;
  logic [DATA_W-1:0]      file_mem [FILE_WORDS];
  logic [DATA_W-1:0]      acc_nxt;
  logic                   zero_nxt;
  logic                   carry_nxt;
  logic                   gie_nxt;
  logic [PC_W-1:0]        pc_nxt;
  file_wr_t               file_wr_nxt;

  wire logic              take;
  wire logic              long_op;
  wire logic              is_load;
  wire logic              is_store;
  wire logic              is_copy;
  wire logic              is_exit_lit;
  wire logic              is_irq_exit;
  wire logic              is_call;
  wire logic              rot_op;
  wire logic              ret_op;
  wire logic              to_file;
  wire logic [DATA_W-1:0] src_data;
  wire logic [DATA_W-1:0] rot_result;
  wire logic              rot_carry;
  wire logic [PC_W-1:0]   pc_inc;
  wire logic [PC_W-1:0]   stack_top;
  wire logic [$clog2(DEPTH)-1:0] stack_level;
  wire logic              push;
  wire logic              pop;

  // a new instruction is only taken between instructions; the decoder holds it
  assign take        = ce && instr_valid && (state_r == st_ready);
  assign is_load     = instr.opcode == op_load_literal_to_accumulator;
  assign is_store    = instr.opcode == op_store_accumulator_to_file;
  assign is_copy     = instr.opcode == op_copy_file_register;
  assign is_exit_lit = instr.opcode == op_exit_with_literal;
  assign is_irq_exit = instr.opcode == op_interrupt_exit_enable;
  assign is_call     = instr.opcode == op_far_subroutine_jump;
  assign rot_op      = is_rotate(instr.opcode);
  assign ret_op      = is_return(instr.opcode);
  assign long_op     = ret_op || is_call;
  assign to_file     = instr.dest_sel == DEST_FILE;
  assign src_data    = file_mem[instr.file_addr];
  assign pc_inc      = PC_W'(pc_r + PC_STEP);
  assign push        = take && is_call;
  assign pop         = take && ret_op;

  rotate_carry_unit u_rotate (
    .src       (src_data),
    .carry_in  (carry_r),
    .to_right  (instr.opcode == op_rotate_right_via_carry),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  return_stack #(
    .DEPTH (DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .push      (push),
    .pop       (pop),
    .push_data (pc_inc),
    .top_data  (stack_top),
    .level     (stack_level)
  );

  // accumulator: literal loads, copies and rotates aimed at it
  always_comb begin
    acc_nxt = acc_r;
    if (take && (is_load || is_exit_lit)) begin
      acc_nxt = instr.literal;
    end else if (take && is_copy && !to_file) begin
      acc_nxt = src_data;
    end else if (take && rot_op && !to_file) begin
      acc_nxt = rot_result;
    end
  end

  // file register writes: store, copy back, rotate back
  always_comb begin
    file_wr_nxt      = '0;
    file_wr_nxt.addr = instr.file_addr;
    if (take && is_store) begin
      file_wr_nxt.en   = 1'h1;
      file_wr_nxt.data = acc_r;
    end else if (take && is_copy && to_file) begin
      file_wr_nxt.en   = 1'h1;
      file_wr_nxt.data = src_data;
    end else if (take && rot_op && to_file) begin
      file_wr_nxt.en   = 1'h1;
      file_wr_nxt.data = rot_result;
    end
  end

  // only copy touches zero and only rotates touch carry
  assign zero_nxt  = (take && is_copy) ? (src_data == ZERO_VALUE) : zero_r;
  assign carry_nxt = (take && rot_op) ? rot_carry : carry_r;
  assign gie_nxt   = (take && (is_exit_lit || is_irq_exit)) ? GIE_ON : gie_r;

  // program counter: returns pop, the call jumps, all else steps by one
  always_comb begin
    pc_nxt = pc_r;
    if (take && ret_op) begin
      pc_nxt = stack_top;
    end else if (take && is_call) begin
      pc_nxt = instr.target;
    end else if (take) begin
      pc_nxt = pc_inc;
    end
  end

  // two-cycle instructions spend their second cycle in st_second
  assign state_nxt = (take && long_op) ? st_second : st_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= st_ready;
      busy_r  <= 1'h0;
      done_r  <= 1'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      busy_r  <= state_nxt == st_second;
      done_r  <= (take && !long_op) || (state_r == st_second);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r         <= ACC_RESET;
      zero_r        <= FLAG_RESET;
      carry_r       <= FLAG_RESET;
      gie_r         <= GIE_RESET;
      pc_r          <= PC_RESET;
      stack_level_r <= '0;
      file_wr_r     <= '0;
    end else if (ce) begin
      acc_r         <= acc_nxt;
      zero_r        <= zero_nxt;
      carry_r       <= carry_nxt;
      gie_r         <= gie_nxt;
      pc_r          <= pc_nxt;
      stack_level_r <= stack_level;
      file_wr_r     <= file_wr_nxt;
    end
  end

  // file contents are data, not control, so they carry no reset
  always_ff @(posedge clk) begin
    if (ce && file_wr_nxt.en) begin
      file_mem[file_wr_nxt.addr] <= file_wr_nxt.data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (srst);

  sequence second_cycle_done;
    // a frozen second cycle stretches the instruction, so only an enabled edge must finish it
    busy_r && !done_r ##1 (done_r || !$past(ce));
  endsequence

  sequence flags_kept;
    zero_r == $past(zero_r) && carry_r == $past(carry_r);
  endsequence

  a_literal_load: assert property (
    take && is_load |=> acc_r == $past(instr.literal) && done_r && !busy_r ##0 flags_kept)
    else $error("literal load did not reach the accumulator in one cycle");

  a_store_write: assert property (
    take && is_store |=> file_wr_r.en && file_wr_r.addr == $past(instr.file_addr) &&
      file_wr_r.data == $past(acc_r) && done_r ##0 flags_kept)
    else $error("store did not write the accumulator to the file register");

  a_copy_route: assert property (
    take && is_copy |=> (($past(to_file) ? file_wr_r.data : acc_r) == $past(src_data)) &&
      file_wr_r.en == $past(to_file) && done_r)
    else $error("copy sent the value to the wrong place");

  a_copy_zero: assert property (
    take && is_copy |=> zero_r == ($past(src_data) == ZERO_VALUE) &&
      carry_r == $past(carry_r))
    else $error("copy left the zero flag wrong");

  a_exit_literal: assert property (
    take && is_exit_lit |=> acc_r == $past(instr.literal) && pc_r == $past(stack_top) &&
      gie_r ##0 second_cycle_done)
    else $error("exit with literal misbehaved");

  a_stack_pop: assert property (
    take && ret_op |=> stack_level == ($past(stack_level) - 1'b1))
    else $error("return did not drop the stack level by one");

  a_irq_exit: assert property (
    take && is_irq_exit |=> pc_r == $past(stack_top) && gie_r &&
      acc_r == $past(acc_r) ##0 flags_kept ##0 second_cycle_done)
    else $error("interrupt exit misbehaved");

  a_sub_exit: assert property (
    take && instr.opcode == op_subroutine_exit |=> pc_r == $past(stack_top) &&
      acc_r == $past(acc_r) && gie_r == $past(gie_r) ##0 flags_kept ##0 second_cycle_done)
    else $error("subroutine exit changed more than the program counter");

  a_rotate_left: assert property (
    take && instr.opcode == op_rotate_left_via_carry |=> carry_r == $past(src_data[MSB]) &&
      (($past(to_file) ? file_wr_r.data : acc_r) == {$past(src_data[MSB-1:0]), $past(carry_r)})
      && zero_r == $past(zero_r) && done_r)
    else $error("rotate left result or carry wrong");

  a_rotate_right: assert property (
    take && instr.opcode == op_rotate_right_via_carry |=> carry_r == $past(src_data[0]) &&
      (($past(to_file) ? file_wr_r.data : acc_r) == {$past(carry_r), $past(src_data[MSB:1])})
      && zero_r == $past(zero_r) && done_r)
    else $error("rotate right result or carry wrong");

  a_rotate_dest: assert property (
    take && rot_op |=> file_wr_r.en == $past(to_file) &&
      (file_wr_r.en || acc_r == $past(rot_result)))
    else $error("rotate destination select ignored");

  a_call_push: assert property (
    take && is_call |=> pc_r == $past(instr.target) && stack_top == $past(pc_inc) &&
      stack_level == ($past(stack_level) + 1'b1) ##0 second_cycle_done)
    else $error("call did not push the next address");

  a_idle_step: assert property (
    take && instr.opcode == op_idle_instruction |=> pc_r == $past(pc_inc) &&
      acc_r == $past(acc_r) && !file_wr_r.en && stack_level == $past(stack_level) &&
      gie_r == $past(gie_r) && done_r ##0 flags_kept)
    else $error("idle instruction changed state");

  a_busy_single: assert property (
    busy_r && ce |=> !busy_r && done_r)
    else $error("second cycle of a long instruction did not end");

  a_busy_refuse: assert property (
    busy_r && instr_valid |=> acc_r == $past(acc_r) && pc_r == $past(pc_r) &&
      !file_wr_r.en && stack_level == $past(stack_level))
    else $error("instruction taken during the second cycle");

  a_freeze_hold: assert property ( // enable low freezes all state
    !ce |=> acc_r == $past(acc_r) && pc_r == $past(pc_r) && gie_r == $past(gie_r) &&
      zero_r == $past(zero_r) && carry_r == $past(carry_r) && done_r == $past(done_r) &&
      busy_r == $past(busy_r) && stack_level == $past(stack_level))
    else $error("state moved while the clock enable was low");

endmodule : move_return_rotate_exec

/* File: hw/return_stack.sv */
// hardware return-address stack held in flip-flops
`timescale 1ns/10ps
module return_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 10
) (
  // clock, reset and enable
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  // stack operations
  input  wire logic                     push,
  input  wire logic                     pop,
  input  wire logic [WIDTH-1:0]         push_data,
  output logic      [WIDTH-1:0]         top_data,
  output logic      [$clog2(DEPTH)-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] entry_r [DEPTH];
  logic [PTR_W-1:0] ptr_r;
  wire  logic [PTR_W-1:0] top_idx;

  // pointer wraps: overflow overwrites the oldest entry, as small cores do
  assign top_idx  = PTR_W'(ptr_r - 1'b1);
  assign top_data = entry_r[top_idx];
  assign level    = ptr_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_r <= '0;
    end else if (ce) begin
      if (push) begin
        ptr_r <= PTR_W'(ptr_r + 1'b1);
      end else if (pop) begin
        ptr_r <= top_idx;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      entry_r[ptr_r] <= push_data;
    end
  end

endmodule : return_stack

/* File: hw/rotate_carry_unit.sv */
// one-bit rotate through carry, either direction
`timescale 1ns/10ps
module rotate_carry_unit (
  // operands
  input  wire logic [exec_pkg::DATA_W-1:0] src,
  input  wire logic                        carry_in,
  input  wire logic                        to_right,
  // results
  output logic      [exec_pkg::DATA_W-1:0] result,
  output logic                             carry_out
);

  import exec_pkg::*;

  wire logic [DATA_W-1:0] left_val;
  wire logic [DATA_W-1:0] right_val;

  assign left_val  = {src[MSB-1:0], carry_in};
  assign right_val = {carry_in, src[MSB:1]};
  assign result    = to_right ? right_val : left_val;
  assign carry_out = to_right ? src[0] : src[MSB];

endmodule : rotate_carry_unit

/* File: tb/testbench.sv */
// self-checking bench for the move, return and rotate execution group
`timescale 1ns/10ps
module testbench;
  import exec_pkg::*;

  logic             clk;
  logic             srst;
  logic             ce;
  logic             instr_valid;
  instr_t           instr;
  logic             busy_r;
  logic             done_r;
  logic [7:0]       acc_r;
  logic             zero_r;
  logic             carry_r;
  logic             gie_r;
  logic [9:0]       pc_r;
  logic [2:0]       stack_level_r;
  file_wr_t         file_wr_r;
  int               num_errors;
  int               check_count;
  int               m_acc, m_z, m_c, m_gie, m_pc, lvl;
  int               mem [64];
  int               stk [8];
  logic [7:0]       lfsr_s;

  move_return_rotate_exec #(.DEPTH(8)) dut (
    .clk(clk), .srst(srst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .busy_r(busy_r), .done_r(done_r), .acc_r(acc_r), .zero_r(zero_r),
    .carry_r(carry_r), .gie_r(gie_r), .pc_r(pc_r), .stack_level_r(stack_level_r),
    .file_wr_r(file_wr_r)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  function automatic logic [7:0] rnd();
    lfsr_s = {lfsr_s[6:0], lfsr_s[7] ^ lfsr_s[5] ^ lfsr_s[4] ^ lfsr_s[3]};
    return lfsr_s;
  endfunction : rnd

  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string nm, logic [9:0] exp, logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // address and data only mean something while the write pulse is up
  task automatic chk_wr(file_wr_t exp, file_wr_t got);
    check_count++;
    if (got.en !== exp.en || (exp.en && got !== exp)) begin
      num_errors++;
      $display("FAIL file_wr expected %0h seen %0h", exp, got);
    end
  endtask : chk_wr

  // state, flags and the stack pointer restart; file contents are kept
  task automatic reset_dut(int cycles);
    srst = 1'b1;
    instr_valid = 1'b0;
    repeat (cycles) @(posedge clk);
    #1 srst = 1'b0;
    m_acc = 0;
    m_z = 0;
    m_c = 0;
    m_gie = 0;
    m_pc = 0;
    lvl = 0;
    chk("acc_rst", 10'h000, 10'(acc_r));
    chk("zero_rst", 10'h000, 10'(zero_r));
    chk("carry_rst", 10'h000, 10'(carry_r));
    chk("gie_rst", 10'h000, 10'(gie_r));
    chk("pc_rst", 10'h000, pc_r);
    chk("lvl_rst", 10'h000, 10'(stack_level_r));
    chk("busy_rst", 10'h000, 10'(busy_r));
    chk("done_rst", 10'h000, 10'(done_r));
    chk_wr('0, file_wr_r);
  endtask : reset_dut

  task automatic run_op(opcode_t op, logic [7:0] lit, logic [5:0] a, logic d, logic [9:0] tgt);
    logic     lng;
    logic     rot;
    file_wr_t ew;
    int       src;
    int       res;
    lng = op inside {op_exit_with_literal, op_interrupt_exit_enable, op_subroutine_exit,
                     op_far_subroutine_jump};
    rot = op inside {op_rotate_left_via_carry, op_rotate_right_via_carry};
    ew = '0;
    src = mem[a];
    res = 0;
    instr_valid = 1'b1;
    instr = '{op, lit, a, d, tgt};
    // a frozen edge before the take must not execute anything
    if (rnd() < 8'h30) begin
      ce = 1'b0;
      @(posedge clk);
      #1 ce = 1'b1;
    end
    @(posedge clk);
    #1;
    case (op)
      op_load_literal_to_accumulator: m_acc = lit;
      op_store_accumulator_to_file: begin
        mem[a] = m_acc;
        ew = '{1'b1, a, 8'(m_acc)};
      end
      op_copy_file_register: begin
        m_z = (src == 0);
        if (d) ew = '{1'b1, a, 8'(src)};
        else m_acc = src;
      end
      op_exit_with_literal: begin
        m_acc = lit;
        m_gie = 1;
      end
      op_interrupt_exit_enable: m_gie = 1;
      op_rotate_left_via_carry: begin
        res = ((src << 1) | m_c) & 255;
        m_c = (src >> 7) & 1;
      end
      op_rotate_right_via_carry: begin
        res = (m_c << 7) | (src >> 1);
        m_c = src & 1;
      end
      default: ;
    endcase
    if (rot && d) begin
      mem[a] = res;
      ew = '{1'b1, a, 8'(res)};
    end else if (rot) begin
      m_acc = res;
    end
    if (lng && op != op_far_subroutine_jump) begin
      lvl--;
      m_pc = stk[lvl % 8];
    end else if (lng) begin
      stk[lvl % 8] = (m_pc + 1) % 1024;
      lvl++;
      m_pc = tgt;
    end else begin
      m_pc = (m_pc + 1) % 1024;
    end
    chk("done", 10'(!lng), 10'(done_r));
    chk("busy", 10'(lng), 10'(busy_r));
    chk("acc", 10'(m_acc), 10'(acc_r));
    chk("zero", 10'(m_z), 10'(zero_r));
    chk("carry", 10'(m_c), 10'(carry_r));
    chk("gie", 10'(m_gie), 10'(gie_r));
    chk("pc", 10'(m_pc), pc_r);
    chk_wr(ew, file_wr_r);
    if (lng) begin
      // the decoder presents a load during the busy slot; it must be refused
      instr = '{op_load_literal_to_accumulator, ~lit, a, d, tgt};
      @(posedge clk);
      #1;
      chk("done2", 10'h001, 10'(done_r));
      chk("busy2", 10'h000, 10'(busy_r));
      chk("acc2", 10'(m_acc), 10'(acc_r));
    end
    chk("level", 10'(lvl % 8), 10'(stack_level_r));
  endtask : run_op

  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  initial begin
    logic [7:0] r;
    opcode_t    op;
    num_errors = 0;
    check_count = 0;
    lfsr_s = 8'h53;
    ce = 1'b1;
    instr = '0;
    reset_dut(3);
    // every file word is written first since its contents are not reset
    for (int a = 0; a < 64; a++) begin
      run_op(op_load_literal_to_accumulator, (a == 0) ? 8'h00 : rnd(), 6'h00, 1'b0, 10'h000);
      run_op(op_store_accumulator_to_file, 8'h00, 6'(a), 1'b0, 10'h000);
    end
    for (int i = 0; i < 500; i++) begin
      // a reset in mid-run, between two instructions, must restart from the reset state
      if (i == 250) begin
        reset_dut(2);
      end
      r = rnd();
      op = opcode_t'(r % 10);
      if (lvl == 0 && op inside {op_exit_with_literal, op_interrupt_exit_enable,
                                 op_subroutine_exit}) begin
        op = op_far_subroutine_jump;
      end else if (lvl == 8 && op == op_far_subroutine_jump) begin
        op = op_subroutine_exit;
      end
      r = rnd();
      run_op(op, rnd(), r[5:0], r[7], {r[1:0], rnd()});
    end
    @(posedge clk);
    #1 instr_valid = 1'b0;
    complete_run();
  end
endmodule : testbench
